// ### hdl/dvc_vid_decoder.sv
// Dynamic voltage control front end for the core and graphic rails
`timescale 1ns/10ps
module dvc_vid_decoder
    import dvc_pkg::*;
(
    input wire logic mclk, // System clock, 125 MHz
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [CODE_W-1:0] voltage_id_code, // Code pins
    input wire logic [SEL_W-1:0] vid_target_select, // Target select pins
    input wire logic core_light_load, // Core light-load sense
    input wire logic graphic_light_load, // Graphic light-load sense
    output logic [CODE_W-1:0] core_dac_code, // Core DAC setting
    output logic [CODE_W-1:0] graphic_dac_code, // Graphic DAC setting
    output logic core_pulse_skip_operation, // Core in pulse skip
    output logic graphic_pulse_skip_operation, // Graphic in pulse skip
    output logic core_sw_tick, // Core switching pulse
    output logic graphic_sw_tick // Graphic switching pulse
);
    localparam int IN_W = CODE_W + SEL_W + 2;
    // Field positions in the synchronised pin word
    localparam int GFX_LL_BIT = 0;
    localparam int CORE_LL_BIT = GFX_LL_BIT + 1;
    localparam int SEL_LSB = CORE_LL_BIT + 1;
    localparam int CODE_LSB = SEL_LSB + SEL_W;

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    logic [IN_W-1:0] pin_word;
    logic [IN_W-1:0] meta_q;
    logic [IN_W-1:0] sync_q;

    assign pin_word = {voltage_id_code, vid_target_select, core_light_load, graphic_light_load};

    // Pins are asynchronous to mclk: two flops before any logic
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= pin_word;
            sync_q <= meta_q;
        end
    end

    // Unpack the synchronised word
    logic [CODE_W-1:0] code_s;
    logic [SEL_W-1:0] sel_s;
    logic core_ll_s;
    logic gfx_ll_s;

    assign code_s = sync_q[CODE_LSB +: CODE_W];
    assign sel_s = sync_q[SEL_LSB +: SEL_W];
    assign core_ll_s = sync_q[CORE_LL_BIT];
    assign gfx_ll_s = sync_q[GFX_LL_BIT];

    // ==========================================================
    // Change detection
    // ==========================================================
    logic [CODE_W-1:0] last_code_q;
    logic [CODE_W-1:0] last_code_d;
    logic [SEL_W-1:0] last_sel_q;
    logic [SEL_W-1:0] last_sel_d;
    logic code_moved;
    logic sel_moved;
    logic pins_moved;

    // Compared with the previous synchronised sample
    always_comb begin
        last_code_d = code_s;
        last_sel_d = sel_s;
        code_moved = (code_s != last_code_q);
        sel_moved = (sel_s != last_sel_q);
        // Any move of code or select restarts the hold
        pins_moved = code_moved | sel_moved;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            last_code_q <= '0;
            last_sel_q <= '0;
        end else begin
            last_code_q <= last_code_d;
            last_sel_q <= last_sel_d;
        end
    end

    // ==========================================================
    // Debounce
    // ==========================================================
    logic [DBC_W-1:0] dbc_q;
    logic [DBC_W-1:0] dbc_d;
    logic done_q;
    logic done_d;
    logic settled;

    // Counts synchronised cycles with the same code and select
    always_comb begin
        dbc_d = dbc_q;
        done_d = done_q;
        settled = 1'b0;
        // The cycle of the move counts as the first stable one
        if (pins_moved) begin
            dbc_d = DBC_W'(1);
            done_d = 1'b0;
        end else if (!done_q) begin
            if (dbc_q == DBC_W'(DEBOUNCE_CYC - 1)) begin
                done_d = 1'b1;
                settled = 1'b1;
            end else begin
                dbc_d = dbc_q + DBC_W'(1);
            end
        end
    end

    // Reset treats the all-zero pins as already taken
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dbc_q <= '0;
            done_q <= 1'b1;
        end else begin
            dbc_q <= dbc_d;
            done_q <= done_d;
        end
    end

    // ==========================================================
    // Target select decode
    // ==========================================================
    vid_target_select_e sel_e;
    logic core_load;
    logic gfx_load;

    assign sel_e = vid_target_select_e'(sel_s);

    // Only a settled word reaches a rail
    always_comb begin
        core_load = 1'b0;
        gfx_load = 1'b0;
        unique case (sel_e)
            SEL_CORE: core_load = settled;
            SEL_GRAPHIC: gfx_load = settled;
            SEL_INVALID, SEL_RESERVED: ;
        endcase
    end

    // ==========================================================
    // Switching tick, 1 MHz
    // ==========================================================
    // One divider serves both rails in the same phase
    logic [SWC_W-1:0] swc_q;
    logic [SWC_W-1:0] swc_d;
    logic tick;

    always_comb begin
        tick = (swc_q == SWC_W'(SW_PERIOD_CYC - 1));
        swc_d = tick ? '0 : swc_q + SWC_W'(1);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            swc_q <= '0;
        end else begin
            swc_q <= swc_d;
        end
    end

    // ==========================================================
    // Rails
    // ==========================================================
    // Each rail keeps its own target register
    rail_ctrl_s core_ctrl;
    rail_ctrl_s gfx_ctrl;

    dvc_rail #(.BOOT_CODE(CORE_BOOT_CODE)) u_core (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(core_load),
        .code(code_s),
        .light_load(core_ll_s),
        .tick(tick),
        .ctrl(core_ctrl)
    );

    dvc_rail #(.BOOT_CODE(GFX_BOOT_CODE)) u_graphic (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(gfx_load),
        .code(code_s),
        .light_load(gfx_ll_s),
        .tick(tick),
        .ctrl(gfx_ctrl)
    );

    // ==========================================================
    // Outputs
    // ==========================================================
    // Clamped code drives DAC, higher code lower volts
    assign core_dac_code = core_ctrl.dac_code;
    assign graphic_dac_code = gfx_ctrl.dac_code;
    assign core_pulse_skip_operation = core_ctrl.mode_skip;
    assign graphic_pulse_skip_operation = gfx_ctrl.mode_skip;
    assign core_sw_tick = core_ctrl.sw_tick;
    assign graphic_sw_tick = gfx_ctrl.sw_tick;
endmodule

// ### hdl/dvc_pkg.sv
// Constants and carriers for the dynamic voltage control front end
package dvc_pkg;
    localparam int CODE_W = 7;
    localparam int SEL_W = 2;
    // Clock period in picoseconds (125 MHz)
    localparam int CLK_PERIOD_PS = 8000;
    // Least hold time of a code step
    localparam int DEBOUNCE_NS = 100;
    localparam int DEBOUNCE_CYC = (DEBOUNCE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DBC_W = 5;
    // Switching tick
    localparam int SW_FREQ_KHZ = 1000;
    localparam int SW_PERIOD_CYC = (1000000000 / CLK_PERIOD_PS) / SW_FREQ_KHZ;
    localparam int SWC_W = 8;
    // Code range and power-up targets
    localparam logic [CODE_W-1:0] CODE_MAX_V = 7'h0C;
    localparam logic [CODE_W-1:0] CODE_MIN_V = 7'h60;
    localparam logic [CODE_W-1:0] CORE_BOOT_CODE = 7'h20;
    localparam logic [CODE_W-1:0] GFX_BOOT_CODE = 7'h30;
    // Load sense threshold count for pulse-skip entry
    localparam int LIGHT_LOAD_CYC = 4;
    localparam int LLC_W = 3;

    typedef enum logic [1:0] {
        SEL_INVALID = 2'b00,
        SEL_CORE = 2'b01,
        SEL_GRAPHIC = 2'b10,
        SEL_RESERVED = 2'b11
    } vid_target_select_e;

    typedef enum logic [0:0] {
        MODE_SYNC = 1'b0,
        MODE_SKIP = 1'b1
    } rail_mode_e;

    typedef struct packed {
        logic [CODE_W-1:0] dac_code;
        logic mode_skip;
        logic sw_tick;
    } rail_ctrl_s;
endpackage

// ### hdl/dvc_rail.sv
// One converter rail: target register, automatic mode and switching tick
`timescale 1ns/10ps
module dvc_rail
    import dvc_pkg::*;
#(
    parameter logic [CODE_W-1:0] BOOT_CODE = CORE_BOOT_CODE
) (
    input wire logic mclk, // System clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic load, // Load debounced code
    input wire logic [CODE_W-1:0] code, // Debounced code
    input wire logic light_load, // Load sense, synchronised
    input wire logic tick, // Shared 1 MHz tick
    output rail_ctrl_s ctrl // Registered controls
);
    logic [CODE_W-1:0] target_q, target_d;
    logic [LLC_W-1:0] light_cnt_q, light_cnt_d;
    logic skip_q, skip_d;
    logic tick_q, tick_d;

    always_comb begin
        target_d = target_q;
        if (load) begin
            if (code < CODE_MAX_V) begin
                target_d = CODE_MAX_V;
            end else if (code > CODE_MIN_V) begin
                target_d = CODE_MIN_V;
            end else begin
                target_d = code;
            end
        end
        light_cnt_d = light_cnt_q;
        skip_d = skip_q;
        if (!light_load) begin
            light_cnt_d = '0;
            skip_d = MODE_SYNC;
        end else if (tick) begin
            if (light_cnt_q == LLC_W'(LIGHT_LOAD_CYC - 1)) begin
                skip_d = MODE_SKIP;
            end else begin
                light_cnt_d = light_cnt_q + LLC_W'(1);
            end
        end
        tick_d = tick & ~skip_q;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            target_q <= BOOT_CODE;
            light_cnt_q <= '0;
            skip_q <= MODE_SYNC;
            tick_q <= 1'b0;
        end else begin
            target_q <= target_d;
            light_cnt_q <= light_cnt_d;
            skip_q <= skip_d;
            tick_q <= tick_d;
        end
    end

    // Bit 0 is LSB to DAC
    assign ctrl = '{dac_code: target_q, mode_skip: skip_q, sw_tick: tick_q};
endmodule

// ### verif/dvc_monitor.sv
// Checker for the code decoder outputs
`timescale 1ns/10ps
module dvc_monitor
    import dvc_pkg::*;
(
    input wire logic mclk, // Clock
    input wire logic rst_n, // Reset
    input wire logic [CODE_W-1:0] voltage_id_code, // Code
    input wire logic [SEL_W-1:0] vid_target_select, // Select
    input wire logic core_light_load, // Sense
    input wire logic graphic_light_load, // Sense
    input wire logic [CODE_W-1:0] core_dac_code, // Target
    input wire logic [CODE_W-1:0] graphic_dac_code, // Target
    input wire logic core_pulse_skip_operation, // Mode
    input wire logic graphic_pulse_skip_operation, // Mode
    input wire logic core_sw_tick, // Tick
    input wire logic graphic_sw_tick // Tick
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    logic [8:0] pin_q, pin_d, quiet_q, quiet_d;
    logic [15:0] gap_q, gap_d;
    function automatic logic [CODE_W-1:0] clamp(input logic [CODE_W-1:0] c);
        return (c < CODE_MAX_V) ? CODE_MAX_V : ((c > CODE_MIN_V) ? CODE_MIN_V : c);
    endfunction
    // ====
    // Stable time of the pins and gap between ticks
    always_comb begin
        pin_d = {vid_target_select, voltage_id_code};
        quiet_d = (pin_d != pin_q) ? 9'h000 : quiet_q + {8'h00, quiet_q != 9'h1FF};
        gap_d = core_sw_tick ? 16'h0000 : gap_q + {15'h0000, gap_q != 16'hFFFF};
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_q <= 9'h000;
            quiet_q <= 9'h000;
            gap_q <= 16'hFFFF;
        end else begin
            pin_q <= pin_d;
            quiet_q <= quiet_d;
            gap_q <= gap_d;
        end
    end
    // ====
    // boot targets
    boot_targets_a: assert property ($rose(rst_n) |->
        core_dac_code == CORE_BOOT_CODE && graphic_dac_code == GFX_BOOT_CODE) else $error("boot targets wrong");
    load_wait_a: assert property ($changed(core_dac_code) |-> $past(quiet_q, 2) >= 9'h00C)
        else $error("code taken too early");
    core_sel_a: assert property ($changed(core_dac_code) |-> $past(vid_target_select, 3) == SEL_CORE)
        else $error("core loaded unaddressed");
    gfx_sel_a: assert property ($changed(graphic_dac_code) |-> $past(vid_target_select, 3) == SEL_GRAPHIC)
        else $error("graphic loaded unaddressed");
    core_map_a: assert property ($changed(core_dac_code) |-> core_dac_code == clamp($past(voltage_id_code, 3)))
        else $error("core code mapped wrong");
    hold_invalid_a: assert property (vid_target_select inside {SEL_INVALID, SEL_RESERVED} &&
        quiet_q >= 8 |-> $stable(core_dac_code) && $stable(graphic_dac_code)) else $error("target moved");
    tick_period_a: assert property (core_sw_tick && gap_q != 16'hFFFF |-> gap_q % 125 == 124)
        else $error("tick period wrong");
    skip_exit_a: assert property ($fell(core_light_load) |-> ##[1:4] !core_pulse_skip_operation)
        else $error("pulse skip kept");
    cover property ($changed(core_dac_code));
    cover property ($changed(graphic_dac_code));
    cover property ($rose(core_pulse_skip_operation));
endmodule

// ### verif/dvc_cpu_model.sv
// Processor model driving the code and select pins
`timescale 1ns/10ps
module dvc_cpu_model
    import dvc_pkg::*;
(
    input wire logic mclk, // Clock
    output logic [CODE_W-1:0] voltage_id_code, // Code pins
    output logic [SEL_W-1:0] vid_target_select // Select pins
);
    initial begin
        voltage_id_code = 7'h00;
        vid_target_select = SEL_INVALID;
    end
    task automatic step(input logic [CODE_W-1:0] c, input logic [SEL_W-1:0] s, input int hold);
        @(posedge mclk);
        #1;
        voltage_id_code = c;
        vid_target_select = s;
        repeat (hold) @(posedge mclk);
        #1;
    endtask
endmodule

// ### verif/dvc_vid_decoder_tb.sv
// Self-checking bench for the code decoder
`timescale 1ns/10ps
module dvc_vid_decoder_tb
    import dvc_pkg::*;
;
    typedef struct packed {
        logic [CODE_W-1:0] code;
        logic [SEL_W-1:0] sel;
        logic [CODE_W-1:0] core;
        logic [CODE_W-1:0] gfx;
    } row_s;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic core_light_load = 1'b0;
    logic graphic_light_load = 1'b0;
    logic [CODE_W-1:0] voltage_id_code, core_dac_code, graphic_dac_code;
    logic [SEL_W-1:0] vid_target_select;
    logic core_pulse_skip_operation, graphic_pulse_skip_operation, core_sw_tick, graphic_sw_tick;
    int fails = 0;
    int n_checks = 0;
    int i;
    row_s rows [9] = '{'{7'h40, 2'b01, 7'h40, 7'h30}, '{7'h0C, 2'b10, 7'h40, 7'h0C},
        '{7'h60, 2'b01, 7'h60, 7'h0C}, '{7'h05, 2'b00, 7'h60, 7'h0C}, '{7'h15, 2'b11, 7'h60, 7'h0C},
        '{7'h02, 2'b01, 7'h0C, 7'h0C}, '{7'h7F, 2'b10, 7'h0C, 7'h60}, '{7'h0D, 2'b01, 7'h0D, 7'h60},
        '{7'h2A, 2'b10, 7'h0D, 7'h2A}};
    dvc_vid_decoder dut (
        .mclk(mclk),
        .rst_n(rst_n),
        .voltage_id_code(voltage_id_code),
        .vid_target_select(vid_target_select),
        .core_light_load(core_light_load),
        .graphic_light_load(graphic_light_load),
        .core_dac_code(core_dac_code),
        .graphic_dac_code(graphic_dac_code),
        .core_pulse_skip_operation(core_pulse_skip_operation),
        .graphic_pulse_skip_operation(graphic_pulse_skip_operation),
        .core_sw_tick(core_sw_tick),
        .graphic_sw_tick(graphic_sw_tick)
    );
    dvc_cpu_model cpu (
        .mclk(mclk),
        .voltage_id_code(voltage_id_code),
        .vid_target_select(vid_target_select)
    );
    always #4 mclk = ~mclk;
    // ====
    // Compare, bounded wait and verdict
    task automatic chk(input string what, input logic [CODE_W-1:0] exp, input logic [CODE_W-1:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wait_hi(input logic tick);
        int k;
        for (k = 0; k < 700 && (tick ? core_sw_tick : core_pulse_skip_operation) !== 1'b1; k++) begin
            @(posedge mclk);
            #1;
        end
        if (k == 700) begin
            fails++;
            $display("BAD wait expected 1 seen 0");
            wrap_up();
        end
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        repeat (3) @(posedge mclk);
        foreach (rows[k]) begin
            cpu.step(rows[k].code, rows[k].sel, 20);
            chk("core target", rows[k].core, core_dac_code);
            chk("graphic target", rows[k].gfx, graphic_dac_code);
        end
        cpu.step(7'h33, 2'b01, 8);
        cpu.step(7'h33, 2'b00, 20);
        chk("short step", 7'h0D, core_dac_code);
        cpu.step(7'h22, 2'b10, 20);
        cpu.step(7'h22, 2'b01, 20);
        chk("select change", 7'h22, core_dac_code);
        cpu.step(7'h2B, 2'b01, 12);
        cpu.step(7'h2B, 2'b00, 20);
        chk("minimum step", 7'h2B, core_dac_code);
        core_light_load = 1'b1;
        graphic_light_load = 1'b1;
        wait_hi(1'b0);
        chk("graphic skip", 7'h01, {6'h00, graphic_pulse_skip_operation});
        core_light_load = 1'b0;
        graphic_light_load = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        chk("skip exit", 7'h00, {6'h00, core_pulse_skip_operation});
        chk("graphic skip exit", 7'h00, {6'h00, graphic_pulse_skip_operation});
        wait_hi(1'b1);
        chk("graphic tick", 7'h01, {6'h00, graphic_sw_tick});
        i = 0;
        do begin
            @(posedge mclk);
            #1;
            i++;
        end while (core_sw_tick !== 1'b1 && i < 127);
        chk("tick period", 7'h7D, i[6:0]);
        rst_n = 1'b0;
        #1;
        chk("core reset", CORE_BOOT_CODE, core_dac_code);
        chk("graphic reset", GFX_BOOT_CODE, graphic_dac_code);
        wrap_up();
    end
endmodule
bind dvc_vid_decoder dvc_monitor mon (
    .mclk(mclk),
    .rst_n(rst_n),
    .voltage_id_code(voltage_id_code),
    .vid_target_select(vid_target_select),
    .core_light_load(core_light_load),
    .graphic_light_load(graphic_light_load),
    .core_dac_code(core_dac_code),
    .graphic_dac_code(graphic_dac_code),
    .core_pulse_skip_operation(core_pulse_skip_operation),
    .graphic_pulse_skip_operation(graphic_pulse_skip_operation),
    .core_sw_tick(core_sw_tick),
    .graphic_sw_tick(graphic_sw_tick)
);
